// file: verilog/ifc_pkg.sv
// constants shared by the interrupt flag and enable controller
package ifc_pkg;

   // register byte offsets on the axi4-lite bus
   localparam logic [7:0] OFF_EDGE  = 8'h00;  // pin edge select
   localparam logic [7:0] OFF_CTRL0 = 8'h04;  // primary control 0
   localparam logic [7:0] OFF_CTRL1 = 8'h08;  // primary control 1
   localparam logic [7:0] OFF_GRP0  = 8'h0C;  // group 0 control
   localparam logic [7:0] OFF_GRP1  = 8'h10;  // group 1 control
   localparam logic [7:0] OFF_STAT  = 8'h14;  // sticky event status, write one to clear
   localparam logic [7:0] OFF_MASK  = 8'h18;  // event status mask

   // primary control 0 fields
   localparam int C0_GIE      = 0;  // global enable
   localparam int C0_PIN_EN   = 1;  // pin enable
   localparam int C0_B2_EN    = 2;  // touch overflow or group 0 enable
   localparam int C0_B3_EN    = 3;  // touch threshold or group 1 enable
   localparam int C0_PIN_FLAG = 4;  // pin flag
   localparam int C0_B5_FLAG  = 5;  // touch overflow or group 0 flag
   localparam int C0_B6_FLAG  = 6;  // touch threshold or group 1 flag

   // primary control 1 fields
   localparam int C1_EN0   = 0;  // timer or two-wire enable
   localparam int C1_EN1   = 1;  // tick base enable
   localparam int C1_EN2   = 2;  // eeprom write enable, larger variant
   localparam int C1_FLAG4 = 4;  // timer or two-wire flag
   localparam int C1_FLAG5 = 5;  // tick base flag
   localparam int C1_FLAG6 = 6;  // eeprom write flag, larger variant

   // group control fields
   localparam int G_EN0   = 0;  // overflow or period enable
   localparam int G_EN1   = 1;  // threshold or match a enable
   localparam int G_FLAG4 = 4;  // overflow or period flag
   localparam int G_FLAG5 = 5;  // threshold or match a flag

   // implemented bit masks
   localparam logic [7:0] MASK_EDGE     = 8'h03;
   localparam logic [7:0] MASK_CTRL0    = 8'h7F;
   localparam logic [7:0] MASK_C1_SMALL = 8'h33;
   localparam logic [7:0] MASK_C1_LARGE = 8'h77;
   localparam logic [7:0] MASK_GRP      = 8'h33;
   localparam logic [7:0] RST_BYTE      = 8'h00;

   // pin edge select codes
   localparam logic [1:0] EDGE_OFF  = 2'b00;
   localparam logic [1:0] EDGE_RISE = 2'b01;
   localparam logic [1:0] EDGE_FALL = 2'b10;
   localparam logic [1:0] EDGE_BOTH = 2'b11;

   // event status bit positions
   localparam int EV_PIN     = 0;
   localparam int EV_TTHR    = 1;
   localparam int EV_TOVF    = 2;
   localparam int EV_TICK    = 3;
   localparam int EV_TMR     = 4;
   localparam int EV_TWOWIRE = 5;
   localparam int EV_EEPROM  = 6;
   localparam int EV_MATCHA  = 7;
   localparam int EV_PERIOD  = 8;
   localparam int EV_N       = 9;
   localparam logic [EV_N-1:0] EV_MASK_SMALL = 9'h01F;
   localparam logic [EV_N-1:0] EV_MASK_LARGE = 9'h1EF;
   localparam logic [EV_N-1:0] RST_EV        = 9'h000;

   // axi response codes
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// file: verilog/ifc_edge_if.sv
// carrier between the controller and its pin edge detector
`timescale 1ns/100ps
interface ifc_edge_if;
   logic       pin_level;   // sampled external pin
   logic [1:0] edge_sel;    // edge select field
   logic       edge_pulse;  // one cycle per selected edge

   modport ctrl_side (output pin_level, output edge_sel, input edge_pulse);
   modport edge_side (input pin_level, input edge_sel, output edge_pulse);
endinterface

// file: verilog/ifc_pin_edge.sv
// external pin edge detector steered by the edge select field
`timescale 1ns/100ps
module ifc_pin_edge
   import ifc_pkg::*;
(
   input  wire logic   aclk,
   input  wire logic   aresetn,
   ifc_edge_if.edge_side port_e
);
   logic prev;    // pin level one cycle ago
   logic primed;  // prev holds a real sample

   // remember last level; first sample after reset is no edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev   <= 1'b0;
         primed <= 1'b0;
      end else begin
         prev   <= port_e.pin_level;
         primed <= 1'b1;
      end
   end

   // code bit 0 selects rising, bit 1 falling; 00 gives nothing
   always_comb begin
      port_e.edge_pulse = primed &
         ((port_e.edge_sel[0] & ~prev & port_e.pin_level) |
          (port_e.edge_sel[1] & prev & ~port_e.pin_level));
   end
endmodule

// file: verilog/ifc_top.sv
// interrupt flag and enable controller with an axi4-lite register slave
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
module ifc_top
   import ifc_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b0  // 1 selects the grouped larger variant
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // event sources
   input  wire logic        ext_pin,
   input  wire logic        touch_threshold_evt,
   input  wire logic        touch_overflow_evt,
   input  wire logic        tick_base_evt,
   input  wire logic        tmr_event_evt,
   input  wire logic        twowire_evt,
   input  wire logic        eeprom_wr_evt,
   input  wire logic        compare_match_a_evt,
   input  wire logic        compare_period_evt,
   // to the processor core and system
   output logic             core_irq_req,
   output logic             irq
);
   // variant dependent implemented masks
   localparam logic [7:0]      MASK_C1 = LARGE_VARIANT ? MASK_C1_LARGE : MASK_C1_SMALL;
   localparam logic [7:0]      MASK_G  = LARGE_VARIANT ? MASK_GRP : RST_BYTE;
   localparam logic [EV_N-1:0] EV_MASK = LARGE_VARIANT ? EV_MASK_LARGE : EV_MASK_SMALL;

   // register storage
   logic [7:0]      edge_select_reg;  // pin edge select
   logic [7:0]      primary_ctrl0;    // global, pin and touch or group bits
   logic [7:0]      primary_ctrl1;    // tick, timer, two-wire, eeprom bits
   logic [7:0]      group0_ctrl;      // touch pair, larger variant
   logic [7:0]      group1_ctrl;      // compare pair, larger variant
   logic [EV_N-1:0] ev_status;        // sticky event record
   logic [EV_N-1:0] ev_mask;          // event record mask

   // bus slave state
   logic        aw_full;   // write address captured
   logic        w_full;    // write data captured
   logic [7:0]  aw_addr;   // captured write address
   logic [31:0] w_data;    // captured write data
   logic [3:0]  w_strb;    // captured strobes
   logic        wr_do;     // the write takes effect this cycle

   // next values
   logic [7:0]      next_edge;
   logic [7:0]      next_ctrl0;
   logic [7:0]      next_ctrl1;
   logic [7:0]      next_grp0;
   logic [7:0]      next_grp1;
   logic [EV_N-1:0] next_status;
   logic [EV_N-1:0] next_mask;
   logic [31:0]     next_rdata;
   logic            rd_hit;     // read address is mapped
   logic            wr_hit;     // write address is mapped

   // hardware set terms and request terms
   logic            pin_edge;   // selected pin edge seen
   logic            grp0_req;   // enabled member of group 0 pending
   logic            grp1_req;   // enabled member of group 1 pending
   logic [7:0]      set_ctrl0;
   logic [7:0]      set_ctrl1;
   logic [7:0]      set_grp0;
   logic [7:0]      set_grp1;
   logic [EV_N-1:0] ev_vec;     // raw events this cycle
   logic            any_req;    // some flag with its enable set

   // pin edge detector
   ifc_edge_if edge_bus ();

   assign edge_bus.pin_level = ext_pin;
   assign edge_bus.edge_sel  = edge_select_reg[1:0];
   assign pin_edge           = edge_bus.edge_pulse;

   ifc_pin_edge u_pin_edge (
      .aclk    (aclk),
      .aresetn (aresetn),
      .port_e  (edge_bus.edge_side)
   );

   // ---------------- axi4-lite write side ----------------

   // address and data taken in either order; refused while a response waits
   assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_full & ~s_axi_bvalid;
   assign wr_do         = aw_full & w_full & ~s_axi_bvalid;

   // capture write address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_do) begin
         aw_full <= 1'b0;
      end
   end

   // capture write data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_do) begin
         w_full <= 1'b0;
      end
   end

   // write decode on the word address; the low two address bits are ignored
   always_comb begin
      unique case ({aw_addr[7:2], 2'b00})
         OFF_EDGE, OFF_CTRL0, OFF_CTRL1, OFF_GRP0,
         OFF_GRP1, OFF_STAT, OFF_MASK: wr_hit = 1'b1;
         default:                      wr_hit = 1'b0;  // unmapped
      endcase
   end

   // write response one cycle after both halves are in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ---------------- hardware set terms ----------------

   // group flag is set by any enabled member flag and stays set until written clear
   assign grp0_req = (group0_ctrl[G_FLAG5] & group0_ctrl[G_EN1]) |
                     (group0_ctrl[G_FLAG4] & group0_ctrl[G_EN0]);
   assign grp1_req = (group1_ctrl[G_FLAG5] & group1_ctrl[G_EN1]) |
                     (group1_ctrl[G_FLAG4] & group1_ctrl[G_EN0]);

   // which flag bit each event sets, per variant
   always_comb begin
      set_ctrl0 = 8'h00;
      set_ctrl1 = 8'h00;
      set_grp0  = 8'h00;
      set_grp1  = 8'h00;
      set_ctrl0[C0_PIN_FLAG] = pin_edge;
      if (LARGE_VARIANT) begin
         set_ctrl0[C0_B5_FLAG] = grp0_req;
         set_ctrl0[C0_B6_FLAG] = grp1_req;
         set_ctrl1[C1_FLAG6]   = eeprom_wr_evt;
         set_ctrl1[C1_FLAG5]   = tick_base_evt;
         set_ctrl1[C1_FLAG4]   = twowire_evt;
         set_grp0[G_FLAG5]     = touch_threshold_evt;
         set_grp0[G_FLAG4]     = touch_overflow_evt;
         set_grp1[G_FLAG5]     = compare_match_a_evt;
         set_grp1[G_FLAG4]     = compare_period_evt;
      end else begin
         set_ctrl0[C0_B5_FLAG] = touch_overflow_evt;
         set_ctrl0[C0_B6_FLAG] = touch_threshold_evt;
         set_ctrl1[C1_FLAG5]   = tick_base_evt;
         set_ctrl1[C1_FLAG4]   = tmr_event_evt;
      end
   end

   // raw event vector for the sticky status record
   always_comb begin
      ev_vec              = RST_EV;
      ev_vec[EV_PIN]      = pin_edge;
      ev_vec[EV_TTHR]     = touch_threshold_evt;
      ev_vec[EV_TOVF]     = touch_overflow_evt;
      ev_vec[EV_TICK]     = tick_base_evt;
      ev_vec[EV_TMR]      = tmr_event_evt;
      ev_vec[EV_TWOWIRE]  = twowire_evt;
      ev_vec[EV_EEPROM]   = eeprom_wr_evt;
      ev_vec[EV_MATCHA]   = compare_match_a_evt;
      ev_vec[EV_PERIOD]   = compare_period_evt;
      ev_vec              = ev_vec & EV_MASK;  // sources absent in this variant
   end

   // ---------------- register next values ----------------

   // a write stores its byte, then hardware sets are or-ed on top,
   // so an event in the clearing cycle survives
   always_comb begin
      next_edge   = edge_select_reg;
      next_ctrl0  = primary_ctrl0;
      next_ctrl1  = primary_ctrl1;
      next_grp0   = group0_ctrl;
      next_grp1   = group1_ctrl;
      next_status = ev_status;
      next_mask   = ev_mask;
      if (wr_do && w_strb[0]) begin
         unique case ({aw_addr[7:2], 2'b00})
            OFF_EDGE:  next_edge  = w_data[7:0] & MASK_EDGE;
            OFF_CTRL0: next_ctrl0 = w_data[7:0] & MASK_CTRL0;
            OFF_CTRL1: next_ctrl1 = w_data[7:0] & MASK_C1;
            OFF_GRP0:  next_grp0  = w_data[7:0] & MASK_G;
            OFF_GRP1:  next_grp1  = w_data[7:0] & MASK_G;
            OFF_STAT:  next_status[7:0] = ev_status[7:0] & ~w_data[7:0];
            OFF_MASK:  next_mask[7:0]   = w_data[7:0] & EV_MASK[7:0];
            default: ;  // unmapped: nothing stored
         endcase
      end
      // bit 8 of status and mask sits in byte lane 1
      if (wr_do && w_strb[1]) begin
         if ({aw_addr[7:2], 2'b00} == OFF_STAT) begin
            next_status[EV_N-1] = ev_status[EV_N-1] & ~w_data[8];
         end
         if ({aw_addr[7:2], 2'b00} == OFF_MASK) begin
            next_mask[EV_N-1] = w_data[8] & EV_MASK[EV_N-1];
         end
      end
      next_ctrl0  = next_ctrl0 | (set_ctrl0 & MASK_CTRL0);
      next_ctrl1  = next_ctrl1 | (set_ctrl1 & MASK_C1);
      next_grp0   = next_grp0 | (set_grp0 & MASK_G);
      next_grp1   = next_grp1 | (set_grp1 & MASK_G);
      next_status = next_status | ev_vec;
   end

   // register update; everything starts cleared
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         edge_select_reg <= RST_BYTE;
         primary_ctrl0   <= RST_BYTE;
         primary_ctrl1   <= RST_BYTE;
         group0_ctrl     <= RST_BYTE;
         group1_ctrl     <= RST_BYTE;
      end else begin
         edge_select_reg <= next_edge;
         primary_ctrl0   <= next_ctrl0;
         primary_ctrl1   <= next_ctrl1;
         group0_ctrl     <= next_grp0;
         group1_ctrl     <= next_grp1;
      end
   end

   // sticky status and mask
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ev_status <= RST_EV;
         ev_mask   <= RST_EV;
      end else begin
         ev_status <= next_status;
         ev_mask   <= next_mask;
      end
   end

   // ---------------- requests ----------------

   // each flag paired with its own enable in the primary registers
   assign any_req =
      (primary_ctrl0[C0_PIN_FLAG] & primary_ctrl0[C0_PIN_EN]) |
      (primary_ctrl0[C0_B5_FLAG] & primary_ctrl0[C0_B2_EN])  |
      (primary_ctrl0[C0_B6_FLAG] & primary_ctrl0[C0_B3_EN])  |
      (primary_ctrl1[C1_FLAG4] & primary_ctrl1[C1_EN0])      |
      (primary_ctrl1[C1_FLAG5] & primary_ctrl1[C1_EN1])      |
      (primary_ctrl1[C1_FLAG6] & primary_ctrl1[C1_EN2]);

   // registered outputs; the core suspends while the request stands
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_irq_req <= 1'b0;
         irq          <= 1'b0;
      end else begin
         core_irq_req <= primary_ctrl0[C0_GIE] & any_req;
         irq          <= |(ev_status & ev_mask);
      end
   end

   // ---------------- axi4-lite read side ----------------

   // one read at a time; next address refused until data is taken
   assign s_axi_arready = ~s_axi_rvalid;

   // read mux; upper bits always zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      rd_hit     = 1'b1;
      unique case ({s_axi_araddr[7:2], 2'b00})
         OFF_EDGE:  next_rdata[7:0] = edge_select_reg;
         OFF_CTRL0: next_rdata[7:0] = primary_ctrl0;
         OFF_CTRL1: next_rdata[7:0] = primary_ctrl1;
         OFF_GRP0:  next_rdata[7:0] = group0_ctrl;
         OFF_GRP1:  next_rdata[7:0] = group1_ctrl;
         OFF_STAT:  next_rdata[EV_N-1:0] = ev_status;
         OFF_MASK:  next_rdata[EV_N-1:0] = ev_mask;
         default:   rd_hit = 1'b0;  // unmapped answers with an error
      endcase
   end

   // read data stands until the master takes it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // prot bits carry no meaning here
   logic unused_prot;
   assign unused_prot = ^{s_axi_awprot, s_axi_arprot, w_data[31:9], w_strb[3:2]};

endmodule

// file: tb/ifc_props.sv
// checker for the register bus handshakes and core outputs of the controller
`timescale 1ns/100ps
module ifc_props
   import ifc_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        core_irq_req,
   input wire logic        irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // read address accepted this edge
   wire ar_take = s_axi_arvalid && s_axi_arready;
   // a pending read answer refuses the next address
   ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   aw_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   // both halves on one edge: response two edges on
   b_time_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write response late");
   r_time_a: assert property (ar_take |=> s_axi_rvalid)
      else $error("read answer late");
   b_end_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not released");
   r_end_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer not released");
   unmap_rd_a: assert property (ar_take && s_axi_araddr[7:2] > OFF_MASK[7:2]
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   edge_top_a: assert property (ar_take && s_axi_araddr == OFF_EDGE
      |=> s_axi_rdata[31:2] == 30'h0) else $error("edge select upper bits not zero");
   // outputs quiet right after reset
   rst_quiet_a: assert property ($rose(aresetn)
      |-> !core_irq_req && !irq && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs active after reset");
   rd_wide_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:9] == 23'h0)
      else $error("read data beyond register width");
endmodule

// file: tb/ifc_src_model.sv
// event source model for the touch, timer, tick and bus peripherals
`timescale 1ns/100ps
module ifc_src_model (
   input  wire logic       aclk,
   input  wire logic [7:0] fire,  // request per source
   output logic      [7:0] evt    // strobes to the controller
);
   // each request becomes one strobe a clock later
   always_ff @(posedge aclk) begin
      evt <= fire;
   end
endmodule

// file: tb/testbench.sv
// self-checking bench of the interrupt flag and enable controller
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
   $display("unexpected at %0t got %0h exp %0h", $time, g, e); end end
module testbench;
   import ifc_pkg::*;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ext_pin;
   logic        awready, wready, bvalid, arready, rvalid, core_irq_req, irq, core_irq_req_l;
   logic [7:0]  awaddr, araddr, fire, evt;
   logic [31:0] wdata, rdata, rdata_l, rdl;
   logic [1:0]  bresp, rresp;
   int          fails = 0, num_checks = 0, cyc = 0;
   ifc_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ext_pin(ext_pin), .touch_threshold_evt(evt[0]), .touch_overflow_evt(evt[1]),
      .tick_base_evt(evt[2]), .tmr_event_evt(evt[3]), .twowire_evt(evt[4]),
      .eeprom_wr_evt(evt[5]), .compare_match_a_evt(evt[6]),
      .compare_period_evt(evt[7]), .core_irq_req(core_irq_req), .irq(irq));
   // larger variant on the same bus; its handshakes match the smaller one's
   ifc_top #(.LARGE_VARIANT(1'b1)) i_dut_l (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(), .s_axi_rdata(rdata_l), .s_axi_rresp(), .s_axi_rvalid(),
      .s_axi_rready(rready), .ext_pin(ext_pin), .touch_threshold_evt(evt[0]),
      .touch_overflow_evt(evt[1]), .tick_base_evt(evt[2]), .tmr_event_evt(evt[3]),
      .twowire_evt(evt[4]), .eeprom_wr_evt(evt[5]), .compare_match_a_evt(evt[6]),
      .compare_period_evt(evt[7]), .core_irq_req(core_irq_req_l), .irq());
   ifc_src_model i_src (.aclk(aclk), .fire(fire), .evt(evt));
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // handshakes judged at the falling edge, where readies have settled
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic pa, pw, ta, tw;
      pa = 1'b1;
      pw = 1'b1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (pa || pw) begin
         @(negedge aclk);
         ta = awready && pa;
         tw = wready && pw;
         @(posedge aclk);
         if (ta) begin
            awvalid <= 1'b0;
            pa = 1'b0;
         end
         if (tw) begin
            wvalid <= 1'b0;
            pw = 1'b0;
         end
      end
      do begin
         @(negedge aclk);
         ta = bvalid;
         r = bresp;
         @(posedge aclk);
      end while (!ta);
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic t;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         t = arready;
         @(posedge aclk);
      end while (!t);
      arvalid <= 1'b0;
      do begin
         @(negedge aclk);
         t = rvalid;
         d = rdata;
         rdl = rdata_l;
         r = rresp;
         @(posedge aclk);
      end while (!t);
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      `CHK(r, RESP_OKAY)
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      `CHK(d, e)
      `CHK(r, RESP_OKAY)
   endtask
   // every register clear after reset, unmapped place refused
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      for (int i = 0; i < 7; i++) rchk(8'(4 * i), 32'h0);
      rd(8'h1C, d, r);
      `CHK(r, RESP_SLVERR)
      wr(8'h1C, 32'hFF, r);
      `CHK(r, RESP_SLVERR)
      $display("test reset done");
   endtask
   // each edge code against a rising then a falling pin
   task automatic t_edge;
      w(OFF_EDGE, 32'hFF);
      rchk(OFF_EDGE, 32'h3);
      for (int c = 0; c < 4; c++) begin
         w(OFF_EDGE, 32'(c));
         ext_pin <= 1'b1;
         repeat (4) @(posedge aclk);
         rchk(OFF_CTRL0, 32'(c[0]) << 4);
         w(OFF_CTRL0, 32'h0);
         ext_pin <= 1'b0;
         repeat (4) @(posedge aclk);
         rchk(OFF_CTRL0, 32'(c[1]) << 4);
         w(OFF_CTRL0, 32'h0);
      end
      w(OFF_STAT, 32'h1FF);
      $display("test edge done");
   endtask
   // sources of the smaller variant: flag, gating, status and mask
   task automatic t_src;
      logic [7:0]  ra [4] = '{OFF_CTRL0, OFF_CTRL0, OFF_CTRL1, OFF_CTRL1};
      int          fb [4] = '{C0_B6_FLAG, C0_B5_FLAG, C1_FLAG5, C1_FLAG4};
      int          eb [4] = '{C0_B3_EN, C0_B2_EN, C1_EN1, C1_EN0};
      logic [31:0] en, fl, sb;
      for (int i = 0; i < 4; i++) begin
         en = (32'h1 << eb[i]) | 32'(ra[i] == OFF_CTRL0);
         fl = 32'h1 << fb[i];
         sb = 32'h1 << (i + 1);
         w(OFF_CTRL0, 32'h1);
         w(ra[i], en);
         fire <= 8'(1 << i);
         @(posedge aclk);
         fire <= 8'h0;
         repeat (5) @(posedge aclk);
         rchk(ra[i], en | fl);
         `CHK(core_irq_req, 1'b1)
         w(OFF_CTRL0, (ra[i] == OFF_CTRL0) ? (en | fl) & ~32'h1 : 32'h0);
         repeat (3) @(posedge aclk);
         `CHK(core_irq_req, 1'b0)
         `CHK(irq, 1'b0)
         rchk(OFF_STAT, sb);
         w(OFF_MASK, sb);
         repeat (3) @(posedge aclk);
         `CHK(irq, 1'b1)
         w(OFF_STAT, sb);
         repeat (3) @(posedge aclk);
         `CHK(irq, 1'b0)
         w(ra[i], 32'h0);
         w(OFF_CTRL0, 32'h0);
         rchk(ra[i], 32'h0);
      end
      $display("test sources done");
   endtask
   // larger variant: group routing and its two-wire and eeprom control 1 sources
   task automatic t_large;
      logic [31:0] d;
      logic [1:0]  r;
      w(OFF_CTRL0, 32'h0D);
      w(OFF_CTRL1, 32'h05);
      w(OFF_GRP0, 32'h02);
      w(OFF_GRP1, 32'h02);
      fire <= 8'h71;
      @(posedge aclk);
      fire <= 8'h0;
      repeat (5) @(posedge aclk);
      `CHK(core_irq_req_l, 1'b1)
      rd(OFF_GRP0, d, r);
      `CHK(rdl, 32'h22)
      rd(OFF_GRP1, d, r);
      `CHK(rdl, 32'h22)
      rd(OFF_CTRL0, d, r);
      `CHK(rdl, 32'h6D)
      rd(OFF_CTRL1, d, r);
      `CHK(rdl, 32'h55)
      rd(OFF_STAT, d, r);
      `CHK(rdl, 32'hE2)
      w(OFF_GRP0, 32'h0);
      w(OFF_GRP1, 32'h0);
      w(OFF_CTRL1, 32'h0);
      w(OFF_CTRL0, 32'h0);
      w(OFF_STAT, 32'h1FF);
      rd(OFF_CTRL0, d, r);
      `CHK(rdl, 32'h0)
      `CHK(core_irq_req_l, 1'b0)
      $display("test large done");
   endtask
   task results;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // watchdog well above the few hundred cycles the tests need
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         results;
      end
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, ext_pin} = 7'h0;
      {awaddr, araddr, fire, wdata} = 56'h0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset;
      t_edge;
      t_src;
      t_large;
      results;
   end
endmodule
bind ifc_top ifc_props u_props (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .core_irq_req(core_irq_req), .irq(irq));
